/* common/ext_bus_pkg.sv */
package ext_bus_pkg;

  localparam int unsigned SEG_W  = 8;
  localparam int unsigned PAGE_W = 2;
  localparam int unsigned ADDR_W = 24;

  // Address areas that leave the core on the bus, and the start of the flash register area.
  localparam logic [23:0] LOW_EXT_END   = 24'h007FFF;
  localparam logic [23:0] MID_EXT_START = 24'h010000;
  localparam logic [23:0] MID_EXT_END   = 24'h1FFFFF;
  localparam logic [23:0] PERIPH_START  = 24'h200000;
  localparam logic [23:0] IO_START      = 24'h200800;
  localparam logic [23:0] IO_END        = 24'h3FFFFF;
  localparam logic [23:0] HIGH_EXT_START = 24'h400000;
  localparam logic [23:0] HIGH_EXT_END  = 24'hBEFFFF;
  localparam logic [23:0] FLASH_REG_START = 24'hFFF000;

  // Value returned for undefined flash register locations; arbitrary.
  localparam logic [15:0] TRAP_CODE = 16'hDEAD;

  // Bus mode codes of the per-region function setting.
  localparam logic [1:0] MODE_DEMUX16 = 2'h0;
  localparam logic [1:0] MODE_MUX16   = 2'h1;
  localparam logic [1:0] MODE_MUX8    = 2'h2;
  localparam logic [1:0] MODE_DEMUX8  = 2'h3;

  localparam int unsigned NUM_WIN = 4;
  localparam int unsigned NUM_CS  = 5;
  localparam int unsigned WAIT_W  = 4;

  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [7:0]  SEG_RESET  = 8'h00;
  localparam logic [4:0]  CS_IDLE    = 5'h1F;

endpackage : ext_bus_pkg

/* rtl/external_bus_unit.sv */
// Behaviour
// - Map is 256 segments of four pages.
// - Every location accessible as byte or word.
// - External memory areas become bus transactions.
// - External IO area runs strictly ordered accesses.
// - Undefined flash register reads return trap code.
// - Single-chip or four mux/width bus modes.
// - Demux: address port plus data port.
// - Mux: data pins carry address then data.
// - Selectable segment lines; unused lines freed.
// - Five chip selects, four windows plus default.
// - Ready input with selectable active level.
// - Arbitration pins idle until software enables.
// - Master drives acknowledge; slave samples it.
// - Timing and function configured per region.
// - Four windows; higher window wins overlaps.
// - Outside all windows uses default region.
// - Selected window asserts its chip select.
// - Bus mode switches per access.
// - Bus timing follows reference clock rising edge.
// - Internal peripheral bus accesses handled alike.
// - Read strobe for every read or fetch.
// - Write strobe per combined or low-byte mode.
// - Address latch enable in multiplexed modes.
// - Mux 8-bit high half carries address only.
module external_bus_unit (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             en_i,
  input  wire logic             link_clk_i,
  input  wire logic             req_i,
  input  wire logic [23:0]      addr_i,
  input  wire logic [15:0]      wdata_i,
  input  wire logic             write_i,
  input  wire logic             byte_i,
  input  wire logic             fetch_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic      [15:0]      rdata_o,
  output logic                  trap_o,
  output logic                  io_access_o,
  input  wire logic             single_chip_i,
  input  wire logic [3:0]       seg_lines_i,
  input  wire logic             ready_active_high_i,
  input  wire logic             write_low_mode_i,
  input  wire logic             arb_enable_i,
  input  wire logic             arb_slave_i,
  input  wire logic [3:0]       window_en_i,
  input  wire logic [3:0][11:0] window_base_i,
  input  wire logic [3:0][3:0]  window_size_i,
  input  wire logic [4:0][1:0]  region_mode_i,
  input  wire logic [4:0][3:0]  region_waits_i,
  input  wire logic [4:0]       region_ready_en_i,
  input  wire logic [4:0]       region_cs_en_i,
  output logic                  reference_clock_out_o,
  output logic      [15:0]      address_port_pins_o,
  output logic                  address_port_oe_o,
  input  wire logic [15:0]      data_port_pins_i,
  output logic      [15:0]      data_port_pins_o,
  output logic      [1:0]       data_port_oe_o,
  output logic      [7:0]       segment_o,
  output logic      [7:0]       segment_oe_o,
  output logic      [4:0]       chip_select_b_o,
  output logic                  ale_o,
  output logic                  read_strobe_b_o,
  output logic                  low_byte_write_strobe_b_o,
  output logic                  ctrl_oe_o,
  input  wire logic             ready_i,
  input  wire logic             hold_b_i,
  input  wire logic             grant_acknowledge_b_i,
  output logic                  grant_acknowledge_b_o,
  output logic                  grant_acknowledge_oe_o,
  output logic                  bus_want_request_b_o
);

  typedef enum logic [2:0] {L_IDLE, L_HELD, L_ADDR, L_DATA, L_WAIT, L_DONE} link_state_type;

  function automatic logic win_hit(input logic [23:0] a, input logic [11:0] base,
                                   input logic [3:0] size);
    logic [11:0] m;
    m = 12'hFFF << size;
    return (a[23:12] & m) == (base & m);
  endfunction : win_hit

  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  logic       is_io;
  logic       is_ext;
  logic       is_flash_reg;
  logic [2:0] region;

  always_comb begin
    is_io        = in_range(addr_i, ext_bus_pkg::IO_START, ext_bus_pkg::IO_END);
    is_ext       = !single_chip_i && (addr_i <= ext_bus_pkg::LOW_EXT_END
                   || in_range(addr_i, ext_bus_pkg::MID_EXT_START, ext_bus_pkg::MID_EXT_END)
                   || in_range(addr_i, ext_bus_pkg::PERIPH_START, ext_bus_pkg::IO_END)
                   || in_range(addr_i, ext_bus_pkg::HIGH_EXT_START,
                               ext_bus_pkg::HIGH_EXT_END));
    is_flash_reg = addr_i >= ext_bus_pkg::FLASH_REG_START;
    region       = 3'h0;
    for (int k = 0; k < ext_bus_pkg::NUM_WIN; k++) begin
      if (window_en_i[k] && win_hit(addr_i, window_base_i[k], window_size_i[k])) begin
        region = 3'(k + 1);
      end
    end
  end

  // Request snapshot; stable while busy so the link side may read it freely.
  logic [23:0] h_addr_reg;
  logic [15:0] h_wdata_reg;
  logic        h_write_reg;
  logic        h_byte_reg;
  logic [2:0]  h_region_reg;
  logic [1:0]  h_mode_reg;
  logic [3:0]  h_waits_reg;
  logic        h_rdy_en_reg;
  logic        h_cs_en_reg;
  logic        h_rdy_pol_reg;
  logic        h_wrl_reg;
  logic [3:0]  h_seg_lines_reg;

  logic        busy_reg;
  logic        done_reg;
  logic        posted_reg;
  logic        io_reg;
  logic        trap_reg;
  logic [15:0] rdata_reg;
  logic        req_tgl_reg;
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic        ack_s3_reg;
  logic        ack_tgl_reg;
  logic [15:0] link_rdata_reg;
  logic        ack_seen;

  assign ack_seen = ack_s2_reg ^ ack_s3_reg;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      h_addr_reg      <= 24'h000000;
      h_wdata_reg     <= ext_bus_pkg::DATA_RESET;
      h_write_reg     <= 1'b0;
      h_byte_reg      <= 1'b0;
      h_region_reg    <= 3'h0;
      h_mode_reg      <= ext_bus_pkg::MODE_DEMUX16;
      h_waits_reg     <= 4'h0;
      h_rdy_en_reg    <= 1'b0;
      h_cs_en_reg     <= 1'b0;
      h_rdy_pol_reg   <= 1'b0;
      h_wrl_reg       <= 1'b0;
      h_seg_lines_reg <= 4'h0;
    end else if (en_i && req_i && !busy_reg && is_ext) begin
      h_addr_reg      <= addr_i;
      h_wdata_reg     <= wdata_i;
      h_write_reg     <= write_i && !fetch_i;
      h_byte_reg      <= byte_i;
      h_region_reg    <= region;
      h_mode_reg      <= region_mode_i[region];
      h_waits_reg     <= region_waits_i[region];
      h_rdy_en_reg    <= region_ready_en_i[region];
      h_cs_en_reg     <= region_cs_en_i[region];
      h_rdy_pol_reg   <= ready_active_high_i;
      h_wrl_reg       <= write_low_mode_i;
      h_seg_lines_reg <= seg_lines_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg    <= 1'b0;
      done_reg    <= 1'b0;
      posted_reg  <= 1'b0;
      io_reg      <= 1'b0;
      trap_reg    <= 1'b0;
      rdata_reg   <= ext_bus_pkg::DATA_RESET;
      req_tgl_reg <= 1'b0;
      ack_s3_reg  <= 1'b0;
    end else if (en_i) begin
      ack_s3_reg <= ack_s2_reg;
      done_reg   <= 1'b0;
      if (req_i && !busy_reg) begin
        if (is_ext) begin
          req_tgl_reg <= ~req_tgl_reg;
          busy_reg    <= 1'b1;
          io_reg      <= is_io;
          trap_reg    <= 1'b0;
          // Writes outside the IO area are posted; IO writes wait for the bus.
          posted_reg  <= write_i && !is_io;
          done_reg    <= write_i && !is_io;
        end else begin
          done_reg  <= 1'b1;
          trap_reg  <= is_flash_reg && !write_i;
          rdata_reg <= (is_flash_reg && !write_i) ? ext_bus_pkg::TRAP_CODE
                                                  : ext_bus_pkg::DATA_RESET;
        end
      end else if (ack_seen && busy_reg) begin
        busy_reg <= 1'b0;
        io_reg   <= 1'b0;
        if (!posted_reg) begin
          done_reg  <= 1'b1;
          rdata_reg <= link_rdata_reg;
        end
      end
    end
  end

  assign busy_o      = busy_reg;
  assign done_o      = done_reg;
  assign rdata_o     = rdata_reg;
  assign trap_o      = trap_reg;
  assign io_access_o = io_reg;

  // Link side: every pin, core control level and the request toggle pass two flip-flops first; the request snapshot is read directly.
  logic [21:0] sync_s1_reg;
  logic [21:0] sync_s2_reg;
  logic        rq_s1_reg;
  logic        rq_s2_reg;
  logic        rq_s3_reg;

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_s1_reg <= 22'h0E0000;
      sync_s2_reg <= 22'h0E0000;
      rq_s1_reg   <= 1'b0;
      rq_s2_reg   <= 1'b0;
    end else begin
      sync_s1_reg <= {en_i, arb_enable_i, arb_slave_i, hold_b_i, grant_acknowledge_b_i,
                      ready_i, data_port_pins_i};
      sync_s2_reg <= sync_s1_reg;
      rq_s1_reg   <= req_tgl_reg;
      rq_s2_reg   <= rq_s1_reg;
    end
  end

  logic        l_en;
  logic        l_arb;
  logic        l_slave;
  logic        l_hold_b;
  logic        l_ackin_b;
  logic        l_ready;
  logic [15:0] l_din;

  assign {l_en, l_arb, l_slave, l_hold_b, l_ackin_b, l_ready, l_din} = sync_s2_reg;

  link_state_type state_reg;
  logic           ref_reg;
  logic           pend_reg;
  logic           hi_reg;
  logic [3:0]     cnt_reg;
  logic           step;
  logic           may_start;
  logic           bus8;
  logic           mux;
  logic [23:0]    cur_a;

  // State moves while the reference clock falls, so registered pins change on its rise.
  assign step      = l_en && ref_reg;
  assign may_start = !l_arb || !l_slave || !l_ackin_b;
  assign bus8      = (h_mode_reg == ext_bus_pkg::MODE_MUX8)
                     || (h_mode_reg == ext_bus_pkg::MODE_DEMUX8);
  assign mux       = (h_mode_reg == ext_bus_pkg::MODE_MUX8)
                     || (h_mode_reg == ext_bus_pkg::MODE_MUX16);
  assign cur_a     = {h_addr_reg[23:1], h_addr_reg[0] | hi_reg};

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_reg <= 1'b0;
    end else if (l_en) begin
      ref_reg <= ~ref_reg;
    end
  end

  assign reference_clock_out_o = ref_reg;

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg      <= L_IDLE;
      pend_reg       <= 1'b0;
      hi_reg         <= 1'b0;
      cnt_reg        <= 4'h0;
      ack_tgl_reg    <= 1'b0;
      rq_s3_reg      <= 1'b0;
      link_rdata_reg <= ext_bus_pkg::DATA_RESET;
    end else if (l_en) begin
      rq_s3_reg <= rq_s2_reg;
      if (rq_s2_reg ^ rq_s3_reg) begin
        pend_reg <= 1'b1;
      end
      if (step) begin
        unique case (state_reg)
          L_IDLE: begin
            if (l_arb && !l_slave && !l_hold_b) begin
              state_reg <= L_HELD;
            end else if (pend_reg && may_start) begin
              state_reg <= L_ADDR;
            end
          end
          L_HELD: begin
            if (l_hold_b || !l_arb) begin
              state_reg <= L_IDLE;
            end
          end
          L_ADDR: begin
            cnt_reg   <= h_waits_reg;
            state_reg <= L_DATA;
          end
          L_DATA: begin
            if (cnt_reg == 4'h0) begin
              state_reg <= h_rdy_en_reg ? L_WAIT : L_DONE;
            end else begin
              cnt_reg <= cnt_reg - 4'h1;
            end
          end
          L_WAIT: begin
            if (l_ready == h_rdy_pol_reg) begin
              state_reg <= L_DONE;
            end
          end
          L_DONE: begin
            if (bus8) begin
              if (hi_reg) begin
                link_rdata_reg[15:8] <= l_din[7:0];
              end else begin
                link_rdata_reg <= {8'h00, l_din[7:0]};
              end
            end else if (h_byte_reg) begin
              link_rdata_reg <= {8'h00, h_addr_reg[0] ? l_din[15:8] : l_din[7:0]};
            end else begin
              link_rdata_reg <= l_din;
            end
            if (bus8 && !h_byte_reg && !hi_reg) begin
              hi_reg    <= 1'b1;
              state_reg <= L_ADDR;
            end else begin
              hi_reg      <= 1'b0;
              pend_reg    <= 1'b0;
              ack_tgl_reg <= ~ack_tgl_reg;
              state_reg   <= L_IDLE;
            end
          end
        endcase
      end
    end
  end

  logic        active;
  logic        strobe;
  logic        float_bus;
  logic [15:0] wd;
  logic [15:0] dout_next;
  logic [1:0]  doe_next;

  assign active    = (state_reg == L_ADDR) || (state_reg == L_DATA)
                     || (state_reg == L_WAIT) || (state_reg == L_DONE);
  assign strobe    = (state_reg == L_DATA) || (state_reg == L_WAIT);
  assign float_bus = (state_reg == L_HELD) || (l_arb && l_slave && l_ackin_b);

  always_comb begin
    wd = h_wdata_reg;
    if (bus8) begin
      wd = {8'h00, hi_reg ? h_wdata_reg[15:8] : h_wdata_reg[7:0]};
    end else if (h_byte_reg && h_addr_reg[0]) begin
      wd = {h_wdata_reg[7:0], 8'h00};
    end
    dout_next = wd;
    doe_next  = 2'h0;
    if (state_reg == L_ADDR && mux) begin
      dout_next = cur_a[15:0];
      doe_next  = 2'h3;
    end else if (active && state_reg != L_ADDR) begin
      unique case (h_mode_reg)
        ext_bus_pkg::MODE_MUX8: begin
          dout_next = {cur_a[15:8], wd[7:0]};
          doe_next  = h_write_reg ? 2'h3 : 2'h2;
        end
        ext_bus_pkg::MODE_DEMUX8: doe_next = h_write_reg ? 2'h1 : 2'h0;
        default: doe_next = h_write_reg ? 2'h3 : 2'h0;
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      address_port_pins_o       <= ext_bus_pkg::DATA_RESET;
      address_port_oe_o         <= 1'b0;
      data_port_pins_o          <= ext_bus_pkg::DATA_RESET;
      data_port_oe_o            <= 2'h0;
      segment_o                 <= ext_bus_pkg::SEG_RESET;
      segment_oe_o              <= ext_bus_pkg::SEG_RESET;
      chip_select_b_o           <= ext_bus_pkg::CS_IDLE;
      ale_o                     <= 1'b0;
      read_strobe_b_o           <= 1'b1;
      low_byte_write_strobe_b_o <= 1'b1;
      ctrl_oe_o                 <= 1'b1;
    end else if (l_en) begin
      address_port_pins_o <= cur_a[15:0];
      address_port_oe_o   <= active && !mux;
      data_port_pins_o    <= dout_next;
      data_port_oe_o      <= doe_next;
      segment_o           <= cur_a[23 -: ext_bus_pkg::SEG_W];
      for (int k = 0; k < 8; k++) begin
        segment_oe_o[k] <= active && (4'(k) < h_seg_lines_reg);
      end
      chip_select_b_o <= ext_bus_pkg::CS_IDLE;
      if (active && state_reg != L_DONE && h_cs_en_reg) begin
        chip_select_b_o[h_region_reg] <= 1'b0;
      end
      ale_o                     <= (state_reg == L_ADDR) && mux;
      read_strobe_b_o           <= !(strobe && !h_write_reg);
      low_byte_write_strobe_b_o <= !(strobe && h_write_reg && (!h_wrl_reg || bus8
                                   || !h_byte_reg || !h_addr_reg[0]));
      ctrl_oe_o                 <= !float_bus;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      grant_acknowledge_b_o  <= 1'b1;
      grant_acknowledge_oe_o <= 1'b0;
      bus_want_request_b_o   <= 1'b1;
    end else if (l_en) begin
      grant_acknowledge_b_o  <= state_reg != L_HELD;
      grant_acknowledge_oe_o <= l_arb && !l_slave;
      bus_want_request_b_o   <= !(l_arb && pend_reg && (state_reg == L_HELD
                                 || (l_slave && l_ackin_b)));
    end
  end

endmodule : external_bus_unit

/* bench/ext_bus_asserts.sv */
module ext_bus_asserts (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        link_clk_i,
  input wire logic        arb_enable_i,
  input wire logic        busy_o,
  input wire logic        trap_o,
  input wire logic        io_access_o,
  input wire logic [15:0] rdata_o,
  input wire logic [4:0]  chip_select_b_o,
  input wire logic        ale_o,
  input wire logic        read_strobe_b_o,
  input wire logic        low_byte_write_strobe_b_o,
  input wire logic        ctrl_oe_o,
  input wire logic        address_port_oe_o,
  input wire logic [1:0]  data_port_oe_o,
  input wire logic        grant_acknowledge_b_o,
  input wire logic        grant_acknowledge_oe_o,
  input wire logic        bus_want_request_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  trap_code_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    trap_o |-> rdata_o == ext_bus_pkg::TRAP_CODE) else $error("trap code wrong");
  io_busy_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    io_access_o |-> busy_o) else $error("io flag idle");
  busy_bound_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(busy_o) |-> ##[1:800] !busy_o) else $error("access hung");
  one_select_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $onehot0(~chip_select_b_o)) else $error("two selects");
  strobe_excl_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    !(!read_strobe_b_o && !low_byte_write_strobe_b_o)) else $error("both strobes");
  ale_phase_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    ale_o |-> read_strobe_b_o && low_byte_write_strobe_b_o) else $error("ale late");
  held_float_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    grant_acknowledge_oe_o && !grant_acknowledge_b_o |-> !ctrl_oe_o && !address_port_oe_o
    && data_port_oe_o == 2'h0) else $error("bus driven when held");
  arb_idle_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    !arb_enable_i [*6] |-> !grant_acknowledge_oe_o && bus_want_request_b_o)
    else $error("arbitration active");
endmodule : ext_bus_asserts

bind external_bus_unit ext_bus_asserts chk (.*);

/* bench/ext_bus_partner.sv */
module ext_bus_partner (
  input  wire logic        link_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        mux_i,
  input  wire logic        wide8_i,
  input  wire logic        slow_i,
  input  wire logic        ready_active_high_i,
  input  wire logic        rd_b_i,
  input  wire logic        wr_b_i,
  input  wire logic        ale_i,
  input  wire logic [4:0]  cs_b_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] dout_i,
  input  wire logic [1:0]  doe_i,
  output logic      [15:0] din_o,
  output logic             ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:511];
  logic [15:0] latch_q;
  logic [3:0]  low_cnt;
  logic [3:0]  hold_cnt;
  logic [8:0]  a;
  assign a = mux_i ? latch_q[8:0] : addr_i[8:0];
  // The address is taken while the latch enable is high.
  always @(posedge link_clk_i) if (ale_i) latch_q <= dout_i;
  assign ready_o = (low_cnt >= (slow_i ? 4'h6 : 4'h0)) ~^ ready_active_high_i;
  always @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt <= 4'h0;
      hold_cnt <= 4'h0;
      din_o <= 16'h0000;
    end else begin
      low_cnt <= (rd_b_i && wr_b_i) ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
      hold_cnt <= !rd_b_i ? 4'h3 : hold_cnt - {3'h0, hold_cnt != 4'h0};
      // Released lines hold three cycles, then toggle, so a late sample sees the data only every other cycle.
      if (!rd_b_i) begin
        din_o <= wide8_i ? {~din_o[15:8], mem[a]} : {mem[{a[8:1], 1'b1}], mem[{a[8:1], 1'b0}]};
      end else if (hold_cnt == 4'h0) begin
        din_o <= ~din_o;
      end
      if (!wr_b_i && !(&cs_b_i)) begin
        if (wide8_i || doe_i[0]) mem[wide8_i ? a : {a[8:1], 1'b0}] <= dout_i[7:0];
        if (!wide8_i && doe_i[1]) mem[{a[8:1], 1'b1}] <= dout_i[15:8];
      end
    end
  end
endmodule : ext_bus_partner

/* bench/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] d;
    logic [15:0] m;
    logic        t;
  } exp_type;
  localparam logic [23:0] REG_A [5] = '{24'h600000, 24'h4F0000, 24'h400000, 24'h5F0000, 24'h500000};
  localparam logic [23:0] MAP_A [5] = '{24'h008000, 24'h000010, 24'h200010, 24'h200810, 24'hFFF010};
  localparam logic [4:0]  MAP_C [5] = '{5'h00, 5'h01, 5'h01, 5'h01, 5'h00};
  logic              clock_i, rst_b_i, en_i, link_clk_i, req_i, write_i, byte_i, fetch_i;
  logic [23:0]       addr_i;
  logic [15:0]       wdata_i, rdata_o, address_port_pins_o, data_port_pins_o, data_port_pins_i;
  logic [15:0]       mem_dout;
  logic              single_chip_i, ready_active_high_i, write_low_mode_i, arb_enable_i;
  logic              arb_slave_i, hold_b_i, peer_ack_b, busy_o, done_o, trap_o, io_access_o;
  logic [3:0]        seg_lines_i, window_en_i;
  logic [3:0][11:0]  window_base_i;
  logic [3:0][3:0]   window_size_i;
  logic [4:0][1:0]   region_mode_i;
  logic [4:0][3:0]   region_waits_i;
  logic [4:0]        region_ready_en_i, region_cs_en_i, chip_select_b_o, cs_seen;
  logic              reference_clock_out_o, address_port_oe_o, ale_o, read_strobe_b_o;
  logic              low_byte_write_strobe_b_o, ctrl_oe_o, ready_i, grant_acknowledge_b_o;
  logic              grant_acknowledge_b_i, grant_acknowledge_oe_o, bus_want_request_b_o;
  logic              mux, wide8, slow, io_seen;
  logic [1:0]        data_port_oe_o;
  logic [7:0]        segment_o, segment_oe_o, seg_seen;
  int                error_cnt, check_count, done_cnt, cyc, cyc2, tick;
  exp_type           exq[$];
  exp_type           e;
  logic [15:0]       dat [5];
  assign data_port_pins_i = {data_port_oe_o[1] ? data_port_pins_o[15:8] : mem_dout[15:8],
                             data_port_oe_o[0] ? data_port_pins_o[7:0] : mem_dout[7:0]};
  assign grant_acknowledge_b_i = grant_acknowledge_oe_o ? grant_acknowledge_b_o : peer_ack_b;
  external_bus_unit DUT (.*);
  ext_bus_partner mem_model (.link_clk_i, .rst_b_i, .mux_i(mux), .wide8_i(wide8), .slow_i(slow),
    .ready_active_high_i, .rd_b_i(read_strobe_b_o), .wr_b_i(low_byte_write_strobe_b_o),
    .ale_i(ale_o), .cs_b_i(chip_select_b_o), .addr_i(address_port_pins_o),
    .dout_i(data_port_pins_o), .doe_i(data_port_oe_o), .din_o(mem_dout), .ready_o(ready_i));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #80 link_clk_i = ~link_clk_i;
  end
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  always @(posedge clock_i) begin
    tick++;
    if (io_access_o === 1'b1) io_seen <= 1'b1;
    if (done_o === 1'b1) begin
      done_cnt++;
      e = exq.pop_front();
      chk("rdata", e.d & e.m, rdata_o & e.m);
      chk("trap", {15'h0, e.t}, {15'h0, trap_o});
    end
    if (tick == 20000) begin
      error_cnt++;
      $display("[FAIL] timeout expected 0 seen 1");
      end_sim();
    end
  end
  always @(posedge link_clk_i)
    {seg_seen, cs_seen} <= {seg_seen | segment_oe_o, cs_seen | ~chip_select_b_o};
  task automatic acc(input logic [23:0] a, input logic w, input logic b, input logic [15:0] d,
                     input logic [15:0] m, input logic t);
    int n;
    n = done_cnt;
    exq.push_back(w ? exp_type'{16'h0000, 16'h0000, 1'b0} : exp_type'{d, m, t});
    {seg_seen, cs_seen} = 13'h0;
    io_seen = 1'b0;
    @(posedge clock_i);
    #2;
    {req_i, addr_i, write_i, byte_i, wdata_i} = {1'b1, a, w, b, d};
    @(posedge clock_i);
    #2;
    req_i = 1'b0;
    cyc = 1;
    while (done_cnt == n || busy_o !== 1'b0) begin
      @(posedge clock_i);
      #2;
      cyc++;
    end
  endtask : acc
  initial begin
    {rst_b_i, req_i, write_i, byte_i, fetch_i, single_chip_i, write_low_mode_i} = 7'h00;
    {en_i, ready_active_high_i, hold_b_i, peer_ack_b, arb_enable_i, arb_slave_i} = 6'h3C;
    {addr_i, wdata_i, mux, wide8, slow} = 43'h0;
    {seg_lines_i, window_en_i} = 8'h8F;
    window_base_i = {12'h500, 12'h500, 12'h400, 12'h400};
    window_size_i = {4'h4, 4'h8, 4'h4, 4'h8};
    region_mode_i = {ext_bus_pkg::MODE_MUX8, ext_bus_pkg::MODE_DEMUX16, ext_bus_pkg::MODE_MUX16,
                     ext_bus_pkg::MODE_DEMUX8, ext_bus_pkg::MODE_DEMUX16};
    {region_waits_i, region_ready_en_i, region_cs_en_i} = {20'h22222, 10'h3FF};
    {error_cnt, check_count, done_cnt, tick, cs_seen, io_seen} = '0;
    void'($urandom(75630));
    repeat (20) @(posedge clock_i);
    #2;
    rst_b_i = 1'b1;
    chk("idle pins", 16'h01FC, {7'h0, chip_select_b_o, read_strobe_b_o, ctrl_oe_o,
        grant_acknowledge_oe_o, busy_o});
    $display("test reset ended");
    for (int w = 1; w >= 0; w--) begin
      for (int i = 0; i < 5; i++) begin
        if (w == 1) dat[i] = 16'($urandom);
        {mux, wide8} = {^region_mode_i[i], region_mode_i[i][1]};
        acc(REG_A[i] + 24'(i * 32), w[0], 1'b0, dat[i], 16'hFFFF, 1'b0);
        chk("cs", 16'(1 << i), {11'h0, cs_seen});
        chk("cs idle", 16'h001F, {11'h0, chip_select_b_o});
      end
    end
    $display("test regions ended");
    for (int i = 1; i < 4; i += 2) begin
      {mux, wide8} = {1'b0, i == 1};
      acc(REG_A[i] + 24'h101 + 24'(i), 1'b1, 1'b1, 16'h005A, 16'h0000, 1'b0);
      acc(REG_A[i] + 24'h101 + 24'(i), 1'b0, 1'b1, 16'h005A, 16'h00FF, 1'b0);
    end
    $display("test bytes ended");
    {mux, wide8} = 2'b00;
    for (int p = 0; p < 2; p++) begin
      ready_active_high_i = p[0];
      fetch_i = p[0];
      slow = 1'b0;
      acc(REG_A[0], 1'b0, 1'b0, dat[0], 16'hFFFF, 1'b0);
      cyc2 = cyc;
      slow = 1'b1;
      acc(REG_A[0], 1'b0, 1'b0, dat[0], 16'hFFFF, 1'b0);
      chk("wait stretch", 16'h0001, 16'(cyc > cyc2));
    end
    {fetch_i, slow} = 2'b00;
    $display("test ready ended");
    for (int i = 0; i < 5; i++) begin
      acc(MAP_A[i], 1'b0, 1'b0, ext_bus_pkg::TRAP_CODE, {16{i == 4}}, i == 4);
      chk("cs map", {11'h0, MAP_C[i]}, {11'h0, cs_seen});
      chk("io", 16'(i == 3), {15'h0, io_seen});
    end
    single_chip_i = 1'b1;
    acc(REG_A[0], 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0);
    chk("single chip cs", 16'h0000, {11'h0, cs_seen});
    single_chip_i = 1'b0;
    seg_lines_i = 4'h4;
    acc(REG_A[0], 1'b0, 1'b0, dat[0], 16'hFFFF, 1'b0);
    chk("segment oe", 16'h000F, {8'h0, seg_seen});
    seg_lines_i = 4'h8;
    $display("test map ended");
    {arb_enable_i, hold_b_i} = 2'b10;
    repeat (60) @(posedge clock_i);
    chk("held pins", 16'h0002, {13'h0, grant_acknowledge_b_o, grant_acknowledge_oe_o,
        ctrl_oe_o});
    for (int s = 0; s < 2; s++) begin
      fork
        begin
          repeat (160) @(posedge clock_i);
          #2;
          if (s == 1) chk("want", 16'h0000, {15'h0, bus_want_request_b_o});
          {hold_b_i, peer_ack_b} = {1'b1, s == 0};
        end
      join_none
      acc(REG_A[0], 1'b0, 1'b0, dat[0], 16'hFFFF, 1'b0);
      chk("stall", 16'h0001, 16'(cyc > 150));
      {arb_slave_i, peer_ack_b} = 2'b11;
      repeat (10) @(posedge clock_i);
    end
    {arb_enable_i, arb_slave_i} = 2'b00;
    $display("test arbitration ended");
    end_sim();
  end
endmodule : tb
